/* File: rtl/irq_priority_sense_break.sv */
// Priority levels, address break and upper-line sense control with Avalon-MM registers
`default_nettype none
`include "irq_psb_defines.svh"

module irq_priority_sense_break
    import irq_psb_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [3:0]        avs_byteenable_in,
    input  wire logic [31:0]       avs_writedata_in,
    output logic      [31:0]       avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // Prefetch watch and break exception
    input  wire logic [23:0]       prefetch_addr_in,
    input  wire logic              prefetch_valid_in,
    input  wire logic              break_ack_in,
    output logic                   break_irq_out,
    // External lines 15..8, bit 0 is line 8
    input  wire logic [7:0]        ext_irq_primary_pin_in,
    input  wire logic [7:0]        ext_irq_alternate_pin_in,
    input  wire logic [7:0]        ext_irq_ack_in,
    output logic      [7:0]        ext_irq_status_flag_out,
    // Peripheral requests, index = register*8 + priority bit
    input  wire logic [31:0]       group_req_in,
    output irq_sel_s               irq_sel_out
);

    // Register map: one byte per 32-bit word, data in bits 7:0
    //   00 priority_level_a
    //   04 priority_level_b
    //   08 priority_level_c
    //   0c priority_level_d
    //   10 break_control: bit 7 match flag, bit 0 enable
    //   14 break_addr_high: fetch address 23:16
    //   18 break_addr_mid: fetch address 15:8
    //   1c break_addr_low: fetch address 7:1, bit 0 reads 0
    //   20 sense_ctrl_upper_high: modes of lines 15..12
    //   24 sense_ctrl_upper_low: modes of lines 11..8
    //   28 upper_port_select: 1 takes the alternate pin
    //   2c status flags of lines 15..8
    //   30 enables of lines 15..8
    // Other offsets read zero and drop writes
    // Reserved bits are stored as written

    // Limits of this slice
    //   Lines 7..0 and their registers live elsewhere
    //   Key and wake-up groups arrive ready-made on group_req_in
    //   The nonmaskable input has no level bit here
    //   Break_irq_out bypasses the group selection
    //   Sources clear their own group requests

    // Detect function shared by all eight lines
    function automatic logic sense_hit(input logic [1:0] mode,
                                       input logic       cur,
                                       input logic       prev);
        logic hit;
        hit = 1'b0;
        unique case (sense_mode_e'(mode))
            SENSE_LOW_LEVEL: hit = ~cur;
            SENSE_FALL:      hit = prev & ~cur;
            SENSE_RISE:      hit = ~prev & cur;
            SENSE_BOTH:      hit = prev ^ cur;
        endcase
        return hit;
    endfunction : sense_hit

    // Group index = register * 8 + bit, A = 0 to D = 3
    //   0  watchdog_one
    //   1  watchdog_zero
    //   2  low_voltage_detector
    //   3  ext lines 6, 7
    //   4  ext lines 4, 5
    //   5  ext lines 2, 3
    //   6  ext line 1
    //   7  ext line 0
    //   8  keyboard_mouse_interface
    //   9  timer_x_unit and its Y twin
    //   10 timer_one
    //   11 timer_zero
    //   12 reserved
    //   13 sync_serial_unit
    //   14 cycle_measure_timer, all three
    //   15 converter
    //   16 reserved
    //   17 LPC host interface
    //   18 flash_serial_interface
    //   19 i2c channels one and two
    //   20 i2c_channel_zero
    //   21 reserved
    //   22 serial_channel_one
    //   23 fifo_serial_port
    //   24 reserved
    //   25 pulse_timer_unit 2
    //   26 pulse_timer_unit 1
    //   27 pulse_timer_unit 0
    //   28 wake_up_input, all sixteen
    //   29 key_input, all sixteen
    //   30 ext lines 12..15, also from flags
    //   31 ext lines 8..11, also from flags

    // Level 1 first, then lowest index within a level
    function automatic irq_sel_s pick(input logic [31:0] req, input logic [31:0] lvl);
        irq_sel_s s;
        logic     found_hi;
        logic     found_lo;
        logic [4:0] hi_idx;
        logic [4:0] lo_idx;
        found_hi = 1'b0;
        found_lo = 1'b0;
        hi_idx   = 5'h00;
        lo_idx   = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (req[i] && lvl[i]) begin
                found_hi = 1'b1;
                hi_idx   = 5'(i);
            end
            if (req[i] && !lvl[i]) begin
                found_lo = 1'b1;
                lo_idx   = 5'(i);
            end
        end
        s.valid = found_hi | found_lo;
        s.level = found_hi;
        s.group = found_hi ? hi_idx : lo_idx;
        return s;
    endfunction : pick

    // Registers
    logic [31:0] pri_q;
    logic [7:0]  brk_ctrl_q;
    logic [7:0]  brk_high_q;
    logic [7:0]  brk_mid_q;
    logic [7:0]  brk_low_q;
    logic [7:0]  sense_high_q;
    logic [7:0]  sense_low_q;
    logic [7:0]  port_sel_q;
    logic [7:0]  enable_q;
    logic [7:0]  flag_q;
    logic [7:0]  flag_d;
    logic [7:0]  seen_q;
    logic [7:0]  seen_d;
    logic        match_q;
    logic        match_d;
    logic [7:0]  pin_q;
    logic [7:0]  pin_prev_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    irq_sel_s    sel_q;

    // Bus handshake: one wait cycle, then answer
    //   Cycle 0: request seen, waitrequest high, read data captured
    //   Cycle 1: waitrequest low, a write lands at the closing edge
    //   The next request may start in the cycle after that
    //   Only byte lane 0 carries data; without it a write is dropped
    //   Upper data bits always read as zero
    //   Requests are assumed to hold steady until waitrequest drops
    wire        access   = avs_read_in | avs_write_in;
    wire        wr_go    = avs_write_in & ack_q & avs_byteenable_in[0];
    wire        rd_go    = avs_read_in & ack_q;
    wire [7:0]  wdata    = avs_writedata_in[7:0];
    wire [7:0]  ofs      = 8'(avs_address_in);

    // Write strobes per register
    wire wr_pri_a  = wr_go & (ofs == `OFS_PRI_A);
    wire wr_pri_b  = wr_go & (ofs == `OFS_PRI_B);
    wire wr_pri_c  = wr_go & (ofs == `OFS_PRI_C);
    wire wr_pri_d  = wr_go & (ofs == `OFS_PRI_D);
    wire wr_ctrl   = wr_go & (ofs == `OFS_BRK_CTRL);
    wire wr_high   = wr_go & (ofs == `OFS_BRK_HIGH);
    wire wr_mid    = wr_go & (ofs == `OFS_BRK_MID);
    wire wr_low    = wr_go & (ofs == `OFS_BRK_LOW);
    wire wr_sh     = wr_go & (ofs == `OFS_SENSE_HIGH);
    wire wr_sl     = wr_go & (ofs == `OFS_SENSE_LOW);
    wire wr_psel   = wr_go & (ofs == `OFS_PORT_SEL);
    wire wr_stat   = wr_go & (ofs == `OFS_EXT_STATUS);
    wire wr_en     = wr_go & (ofs == `OFS_EXT_ENABLE);
    wire rd_stat   = rd_go & (ofs == `OFS_EXT_STATUS);

    // Read mux; unmapped offsets read zero
    logic [7:0] rmux;
    always_comb begin
        unique case (ofs)
            `OFS_PRI_A:      rmux = pri_q[7:0];
            `OFS_PRI_B:      rmux = pri_q[15:8];
            `OFS_PRI_C:      rmux = pri_q[23:16];
            `OFS_PRI_D:      rmux = pri_q[31:24];
            `OFS_BRK_CTRL:   rmux = {match_q, brk_ctrl_q[6:0]};
            `OFS_BRK_HIGH:   rmux = brk_high_q;
            `OFS_BRK_MID:    rmux = brk_mid_q;
            `OFS_BRK_LOW:    rmux = {brk_low_q[7:1], 1'b0};
            `OFS_SENSE_HIGH: rmux = sense_high_q;
            `OFS_SENSE_LOW:  rmux = sense_low_q;
            `OFS_PORT_SEL:   rmux = port_sel_q;
            `OFS_EXT_STATUS: rmux = flag_q;
            `OFS_EXT_ENABLE: rmux = enable_q;
            default:         rmux = 8'h00;
        endcase
    end

    assign avs_waitrequest_out = access & ~ack_q;
    assign avs_readdata_out    = rdata_q;

    // Capturing in cycle 0 keeps the mux off the output path; a flag that
    // sets during cycle 1 shows up on the next read instead
    // Bus timing flops; read data captured in the wait cycle
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= access & ~ack_q;
            if (access & ~ack_q) begin
                rdata_q <= {24'h00_0000, rmux};
            end
        end
    end

    // Priority registers; reserved bits are stored as written
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pri_q <= {4{`RST_BYTE}};
        end else begin
            if (wr_pri_a) begin
                pri_q[7:0]   <= wdata;
            end
            if (wr_pri_b) begin
                pri_q[15:8]  <= wdata;
            end
            if (wr_pri_c) begin
                pri_q[23:16] <= wdata;
            end
            if (wr_pri_d) begin
                pri_q[31:24] <= wdata;
            end
        end
    end

    // Break and sense configuration
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            brk_ctrl_q   <= `RST_BYTE;
            brk_high_q   <= `RST_BYTE;
            brk_mid_q    <= `RST_BYTE;
            brk_low_q    <= `RST_BYTE;
            sense_high_q <= `RST_BYTE;
            sense_low_q  <= `RST_BYTE;
            port_sel_q   <= `RST_BYTE;
            enable_q     <= `RST_BYTE;
        end else begin
            if (wr_ctrl) begin
                brk_ctrl_q   <= wdata & `BRK_CTRL_RW_MASK;
            end
            if (wr_high) begin
                brk_high_q   <= wdata;
            end
            if (wr_mid) begin
                brk_mid_q    <= wdata;
            end
            if (wr_low) begin
                brk_low_q    <= wdata & `BRK_LOW_RW_MASK;
            end
            if (wr_sh) begin
                sense_high_q <= wdata;
            end
            if (wr_sl) begin
                sense_low_q  <= wdata;
            end
            if (wr_psel) begin
                port_sel_q   <= wdata;
            end
            if (wr_en) begin
                enable_q     <= wdata;
            end
        end
    end

    // A hit at edge N raises break_irq_out right after N.
    // Clearing the enable hides the request but keeps the flag,
    // so re-enabling shows it again without a new fetch.
    // Limitation: bit 0 is never compared, so an even break address
    // also matches the fetch of its odd neighbour.
    // Software cannot clear the flag itself; only break_ack_in does
    // Address break: bit 0 of the fetch address is never compared
    wire brk_enable = brk_ctrl_q[`POS_BRK_ENABLE];
    wire brk_hit    = prefetch_valid_in & brk_enable &
                      (prefetch_addr_in[23:1] ==
                       {brk_high_q, brk_mid_q, brk_low_q[7:1]});
    // Hit wins over a same-cycle acknowledge so no break is lost
    assign match_d       = brk_hit | (match_q & ~break_ack_in);
    assign break_irq_out = match_q & brk_enable;

    // Line g is line 8 + g and uses sense_all[2g+1:2g], B bit above A:
    //   00 flag while the sample is low
    //   01 flag on a falling sample pair
    //   10 flag on a rising sample pair
    //   11 flag on either change
    // Sense_ctrl_upper_low 7:6 is line 11, 1:0 line 8
    // Sense_ctrl_upper_high 7:6 is line 15, 1:0 line 12
    // A flag shows two edges after its pin moves: sample, then compare.
    // Pulses shorter than a clock may be missed; pins are taken as
    // already synchronous, so no extra flip-flops sit in front.
    // Samples reset high so an idle-high line sees no false edge
    // Level mode re-sets the flag each cycle the sample stays low
    // Per-line sense: pin select, edge compare and flag update
    wire [15:0] sense_all = {sense_high_q, sense_low_q};
    wire [7:0]  pin_sel   = (port_sel_q & ext_irq_alternate_pin_in) |
                            (~port_sel_q & ext_irq_primary_pin_in);
    logic [7:0] hit_v;
    logic [7:0] hw_clr_v;
    for (genvar g = 0; g < 8; g++) begin : g_line
        wire [1:0] mode = sense_all[2*g+1:2*g];
        assign hit_v[g]    = sense_hit(mode, pin_q[g], pin_prev_q[g]);
        // Level mode only lets the acknowledge clear once the pin is high
        assign hw_clr_v[g] = ext_irq_ack_in[g] &
                             ((mode != SENSE_LOW_LEVEL) | pin_q[g]);
    end
    // Status clear paths:
    //   Software writes 0 to a bit it has just read as 1
    //   Ext_irq_ack_in, in level mode only once the sample is high
    // A detect in the clearing cycle wins so no event is lost
    // Software clear needs a prior read of the flag at one
    wire [7:0] sw_clr_v = {8{wr_stat}} & ~wdata & seen_q;
    assign flag_d = hit_v | (flag_q & ~(sw_clr_v | hw_clr_v));
    assign seen_d = flag_d & (seen_q | ({8{rd_stat}} & flag_q));
    assign ext_irq_status_flag_out = flag_q;

    // Sense and break state flops
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_q      <= 8'hff;
            pin_prev_q <= 8'hff;
            flag_q     <= 8'h00;
            seen_q     <= 8'h00;
            match_q    <= 1'b0;
        end else begin
            pin_q      <= pin_sel;
            pin_prev_q <= pin_q;
            flag_q     <= flag_d;
            seen_q     <= seen_d;
            match_q    <= match_d;
        end
    end

    // Enabled external lines join their priority groups in register D
    wire [7:0]  ext_req = flag_q & enable_q;
    wire [31:0] all_req = group_req_in |
                          (32'(|ext_req[3:0]) << (24 + `POS_D_LINES_8_11)) |
                          (32'(|ext_req[7:4]) << (24 + `POS_D_LINES_12_15));
    wire irq_sel_s sel_d = pick(all_req, pri_q);

    // One register stage: irq_sel_out trails the requests by a cycle.
    // Level 1 beats level 0; the lowest index wins inside a level.
    // Trade-off: a fixed order keeps the pick small, but a busy low
    // index can hold off a higher one of the same level.
    // No acknowledge here; the chosen source drops its own request
    // Registered selection toward the CPU
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end
    assign irq_sel_out = sel_q;

endmodule : irq_priority_sense_break
`default_nettype wire

/* File: rtl/irq_psb_defines.svh */
// Offsets, field positions, reset values and write masks of the priority/sense/break block
`ifndef IRQ_PSB_DEFINES_SVH
`define IRQ_PSB_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_PRI_A          8'h00
`define OFS_PRI_B          8'h04
`define OFS_PRI_C          8'h08
`define OFS_PRI_D          8'h0c
`define OFS_BRK_CTRL       8'h10
`define OFS_BRK_HIGH       8'h14
`define OFS_BRK_MID        8'h18
`define OFS_BRK_LOW        8'h1c
`define OFS_SENSE_HIGH     8'h20
`define OFS_SENSE_LOW      8'h24
`define OFS_PORT_SEL       8'h28
`define OFS_EXT_STATUS     8'h2c
`define OFS_EXT_ENABLE     8'h30

// Reset values
`define RST_BYTE           8'h00

// Field positions
`define POS_BRK_ENABLE     0
`define POS_MATCH_FLAG     7
`define POS_D_LINES_8_11   7
`define POS_D_LINES_12_15  6
`define BRK_CTRL_RW_MASK   8'h7f
`define BRK_LOW_RW_MASK    8'hfe

`endif

/* File: rtl/irq_psb_pkg.sv */
// Types shared by the priority/sense/break block
`default_nettype none
package irq_psb_pkg;

    // Two-bit sense field encodings
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_FALL      = 2'b01,
        SENSE_RISE      = 2'b10,
        SENSE_BOTH      = 2'b11
    } sense_mode_e;

    // Request presented to the CPU
    typedef struct packed {
        logic       valid;
        logic       level;
        logic [4:0] group;
    } irq_sel_s;

endpackage : irq_psb_pkg
`default_nettype wire

/* File: verif/irq_psb_props.sv */
// Port-level checker for the priority/sense/break block
`default_nettype none
`include "irq_psb_defines.svh"
module irq_psb_props
    import irq_psb_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              mclk_in,
    input wire logic              rst_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic              avs_read_in,
    input wire logic              avs_write_in,
    input wire logic [31:0]       avs_readdata_out,
    input wire logic              avs_waitrequest_out,
    input wire logic              prefetch_valid_in,
    input wire logic              break_ack_in,
    input wire logic              break_irq_out,
    input wire logic [7:0]        ext_irq_ack_in,
    input wire logic [7:0]        ext_irq_status_flag_out,
    input wire logic [31:0]       group_req_in,
    input wire irq_sel_s          irq_sel_out
);
    // Any request on the register bus
    wire logic req = avs_read_in | avs_write_in;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    chk_wait_first_cycle: assert property (req && !$past(req) |-> avs_waitrequest_out)
        else $error("waitrequest low in first request cycle");
    chk_wait_one_cycle: assert property (req && avs_waitrequest_out ##1 req |-> !avs_waitrequest_out)
        else $error("more than one wait cycle");
    chk_wait_when_idle: assert property (!req |-> !avs_waitrequest_out)
        else $error("waitrequest without request");
    chk_read_upper_zero: assert property (avs_read_in && !avs_waitrequest_out
        |-> avs_readdata_out[31:8] == 24'h0) else $error("upper read bits not zero");
    chk_brk_low_bit: assert property (avs_read_in && !avs_waitrequest_out &&
        avs_address_in == `OFS_BRK_LOW |-> !avs_readdata_out[0]) else $error("low break bit 0 set");
    chk_ack_drops_irq: assert property (break_ack_in && !prefetch_valid_in |=> !break_irq_out)
        else $error("break request outlived ack");
    chk_irq_rise_cause: assert property ($rose(break_irq_out) |->
        $past(prefetch_valid_in) || $past(avs_write_in)) else $error("break request without cause");
    chk_sel_when_quiet: assert property ($past(group_req_in) == 32'h0 &&
        $past(ext_irq_status_flag_out) == 8'h0 |-> !irq_sel_out.valid)
        else $error("request selected with none pending");
    chk_flag_clear_cause: assert property ((($past(ext_irq_status_flag_out) &
        ~ext_irq_status_flag_out) != 8'h0) |-> $past(avs_write_in) || $past(ext_irq_ack_in) != 8'h0)
        else $error("status flag dropped without clear");
endmodule : irq_psb_props

bind irq_priority_sense_break irq_psb_props #(.ADDR_W(ADDR_W)) irq_psb_props_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .prefetch_valid_in(prefetch_valid_in),
    .break_ack_in(break_ack_in), .break_irq_out(break_irq_out), .ext_irq_ack_in(ext_irq_ack_in),
    .ext_irq_status_flag_out(ext_irq_status_flag_out), .group_req_in(group_req_in),
    .irq_sel_out(irq_sel_out));
`default_nettype wire

/* File: verif/cpu_side_model.sv */
// Behavioural CPU exception side that answers break requests
`default_nettype none
module cpu_side_model (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       break_irq_in,
    input  wire logic       ack_en_in,
    input  wire logic [3:0] delay_in,
    output var  logic       break_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // Ack after a chosen delay; one pulse only, since the request drops next cycle
    always_ff @(posedge mclk_in) begin
        if (rst_in || !break_irq_in || break_ack_out) begin
            wait_q        <= 4'h0;
            break_ack_out <= 1'b0;
        end else if (ack_en_in && wait_q == delay_in) begin
            break_ack_out <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : cpu_side_model
`default_nettype wire

/* File: verif/tb_irq_priority_sense_break.sv */
// Self-checking bench for the priority/sense/break block
`default_nettype none
`include "irq_psb_defines.svh"
module tb_irq_priority_sense_break;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0, rst_in = 1'b1, rd_q = 1'b0, wr_q = 1'b0;
    logic        fetch_q = 1'b0, ack_en = 1'b0, brk_ack, brk_irq, waitreq;
    logic [7:0]  addr_q = 8'h00, pri_pin = 8'hff, alt_pin = 8'hff, ext_ack = 8'h00, flag, q;
    logic [31:0] wdata_q = 32'h0, req_q = 32'h0, rdata, pri = 32'h0;
    logic [23:0] fetch_addr = 24'h0;
    logic [3:0]  ack_delay = 4'h0;
    logic [6:0]  sel;
    logic [15:0] r = 16'ha408;
    int          error_cnt = 0, total_checks = 0;

    always #4 mclk_in = ~mclk_in;

    irq_priority_sense_break irq_priority_sense_break_i (
        .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr_q), .avs_read_in(rd_q),
        .avs_write_in(wr_q), .avs_byteenable_in(4'hf), .avs_writedata_in(wdata_q),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .prefetch_addr_in(fetch_addr),
        .prefetch_valid_in(fetch_q), .break_ack_in(brk_ack), .break_irq_out(brk_irq),
        .ext_irq_primary_pin_in(pri_pin), .ext_irq_alternate_pin_in(alt_pin),
        .ext_irq_ack_in(ext_ack), .ext_irq_status_flag_out(flag), .group_req_in(req_q),
        .irq_sel_out(sel));
    cpu_side_model cpu_side_model_i (.mclk_in(mclk_in), .rst_in(rst_in), .break_irq_in(brk_irq),
        .ack_en_in(ack_en), .delay_in(ack_delay), .break_ack_out(brk_ack));

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    // Level 1 beats level 0, lowest index wins within a level
    function automatic logic [6:0] exp_sel(input logic [31:0] req, input logic [31:0] lvl);
        logic [6:0] s;
        s = 7'h00;
        for (int i = 31; i >= 0; i--) if (req[i] && !lvl[i]) s = {2'b10, 5'(i)};
        for (int i = 31; i >= 0; i--) if (req[i] && lvl[i]) s = {2'b11, 5'(i)};
        return s;
    endfunction : exp_sel
    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : step
    // Request held until waitrequest is seen low; one idle edge before the next
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        addr_q <= a;
        wdata_q <= {24'h0, d};
        wr_q <= wr;
        rd_q <= !wr;
        do begin @(posedge mclk_in); n++; end while (waitreq !== 1'b0 && n < 20);
        q = rdata[7:0];
        if (n >= 20) begin error_cnt++; final_report(); end
        rd_q <= 1'b0;
        wr_q <= 1'b0;
        @(posedge mclk_in);
    endtask : bus
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, q, e);
    endtask : rd
    // Released address shows its inverse, not the last value
    task automatic fetch(input logic [23:0] a);
        fetch_addr <= a;
        fetch_q <= 1'b1;
        @(posedge mclk_in);
        fetch_q <= 1'b0;
        fetch_addr <= ~a;
        step(2);
    endtask : fetch
    task automatic pin(input logic alt, input int n, input logic v);
        if (alt) alt_pin[n] <= v;
        else pri_pin[n] <= v;
        step(3);
    endtask : pin

    initial begin
        logic [7:0] wm [10] = '{8'hff, 8'hef, 8'hde, 8'hfe, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
        logic [7:0] v, so;
        logic [23:0] a;
        logic [1:0] m;
        int n;
        step(20);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        chk("break irq reset", brk_irq, 1'b0);
        for (int k = 0; k < 10; k++) rd("reset value", 8'(k * 4), 8'h00);
        bus(1'b1, 8'h3c, 8'h5a);
        rd("unmapped", 8'h3c, 8'h00);
        // Random contents with reserved bits kept at zero
        for (int k = 0; k < 10; k++) begin
            r = nxt(r);
            v = r[7:0] & wm[k];
            bus(1'b1, 8'(k * 4), v);
            rd("readback", 8'(k * 4), v & (k == 7 ? 8'hfe : 8'hff));
            if (k < 4) pri[k*8 +: 8] = v;
        end
        // Priority selection, corners first
        for (int k = 0; k < 18; k++) begin
            r = nxt(r);
            req_q <= k == 0 ? 32'h0 : k == 1 ? ~32'h0 : k == 2 ? ~pri : {r, nxt(r)};
            step(2);
            chk("selected", sel, exp_sel(req_q, pri));
        end
        // Address break at an even address
        r = nxt(r);
        a = {r, r[7:0]} & 24'hfffffe;
        bus(1'b1, `OFS_BRK_HIGH, a[23:16]);
        bus(1'b1, `OFS_BRK_MID, a[15:8]);
        bus(1'b1, `OFS_BRK_LOW, a[7:0]);
        bus(1'b1, `OFS_BRK_CTRL, 8'h00);
        fetch(a);
        chk("break disabled", brk_irq, 1'b0);
        bus(1'b1, `OFS_BRK_CTRL, 8'h01);
        for (int k = 0; k < 3; k++) begin
            fetch(a ^ (24'h1 << (23 - k * 11)));
            chk("break miss", brk_irq, 1'b0);
        end
        fetch(a | 24'h1);
        chk("break hit", brk_irq, 1'b1);
        rd("match flag", `OFS_BRK_CTRL, 8'h81);
        bus(1'b1, `OFS_BRK_CTRL, 8'h00);
        chk("break masked", brk_irq, 1'b0);
        rd("flag kept", `OFS_BRK_CTRL, 8'h80);
        bus(1'b1, `OFS_BRK_CTRL, 8'h01);
        chk("break again", brk_irq, 1'b1);
        ack_delay <= r[3:0];
        ack_en <= 1'b1;
        n = 0;
        while (brk_irq !== 1'b0 && n < 40) begin step(1); n++; end
        chk("break handled", brk_irq, 1'b0);
        if (n >= 40) final_report();
        rd("flag cleared", `OFS_BRK_CTRL, 8'h01);
        // Every sense mode; odd modes through the alternate pin
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            r = nxt(r);
            n = int'(r[2:0]);
            so = n < 4 ? `OFS_SENSE_LOW : `OFS_SENSE_HIGH;
            bus(1'b1, `OFS_PORT_SEL, 8'(m[0]) << n);
            bus(1'b1, so, 8'(m) << (2 * (n % 4)));
            bus(1'b0, `OFS_EXT_STATUS, 8'h00);
            bus(1'b1, `OFS_EXT_STATUS, 8'h00);
            pin(!m[0], n, 1'b0);
            pin(!m[0], n, 1'b1);
            chk("other pin", flag[n], 1'b0);
            pin(m[0], n, 1'b0);
            chk("after fall", flag[n], m != 2);
            bus(1'b0, `OFS_EXT_STATUS, 8'h00);
            bus(1'b1, `OFS_EXT_STATUS, 8'h00);
            chk("clear while low", flag[n], m == 0);
            pin(m[0], n, 1'b1);
            chk("after rise", flag[n], m != 1);
            bus(1'b1, so, 8'h00);
        end
        // Enabled line 8 joins group 31; the exception ack clears its flag
        bus(1'b1, `OFS_PORT_SEL, 8'h00);
        bus(1'b0, `OFS_EXT_STATUS, 8'h00);
        bus(1'b1, `OFS_EXT_STATUS, 8'h00);
        bus(1'b1, `OFS_SENSE_LOW, 8'h01);
        bus(1'b1, `OFS_EXT_ENABLE, 8'h01);
        req_q <= 32'h0;
        pin(1'b0, 0, 1'b0);
        step(1);
        chk("line request", sel, exp_sel(32'h8000_0000, pri));
        ext_ack <= 8'h01;
        step(1);
        ext_ack <= 8'h00;
        step(1);
        chk("line acked", flag[0], 1'b0);
        step(1);
        chk("line dropped", sel, 7'h00);
        pin(1'b0, 0, 1'b1);
        final_report();
    end
endmodule : tb_irq_priority_sense_break
`default_nettype wire
